// File: ccas_defs.vh
/*
  Constants for the communications chip access sequencer.
  Assumes a 40 MHz master clock on I_MCLK.
*/
`ifndef CCAS_DEFS_VH
`define CCAS_DEFS_VH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CCAS_CLK_PERIOD_NS   25
`define CCAS_PHASE_NS        400
`define CCAS_PHASE_CYC       (`CCAS_PHASE_NS / `CCAS_CLK_PERIOD_NS)
`define CCAS_PHASE_CNT_W     4
`define CCAS_RING_W          5
`define CCAS_RING_FIRST      5'h01
`define CCAS_PH_ACCESS       1
`define CCAS_PH_CAPTURE      2
`define CCAS_BIT_RATE        9600
`define CCAS_OVERSAMPLE      32
`define CCAS_CLK_HZ          40000000
`define CCAS_BCLK_HALF       (`CCAS_CLK_HZ / (`CCAS_BIT_RATE * `CCAS_OVERSAMPLE * 2))
`define CCAS_BCLK_CNT_W      8

// ----------------------------------------------------------------------------
// I/O bit addresses on the bit-serial bus
// ----------------------------------------------------------------------------
`define CCAS_BIT_ADDR_W      4
`define CCAS_BIT_SEL0        4'h8
`define CCAS_BIT_SEL1        4'h9
`define CCAS_BIT_SEL2        4'ha
`define CCAS_BIT_STROBE      4'hb
`define CCAS_BIT_MRESET      4'hc

// ----------------------------------------------------------------------------
// Addresses and reset values
// ----------------------------------------------------------------------------
`define CCAS_WSEL_W          3
`define CCAS_WSEL_RST        3'h0
`define CCAS_PTR_W           3
`define CCAS_PTR_RST         3'h0
`define CCAS_PTR_STATUS      3'h1
`define CCAS_DATA_W          8
`define CCAS_DATA_RST        8'h00

`endif

// File: ccas_ring.v
/*
  Ring counter timing a chip access, one phase per 400 ns.
  Assumes the start request is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`include "ccas_defs.vh"

module ccas_ring (
  // Clock and reset
  input  wire                       i_clk,
  input  wire                       i_arst_n,
  // Control
  input  wire                       i_start,
  // Phases
  output reg  [`CCAS_RING_W-1:0]    o_phase,
  output reg                        o_done
);

  reg                          ring_advance_enable_r;
  reg [`CCAS_PHASE_CNT_W-1:0]  cnt_r;
  wire                         tick;

  assign tick = (cnt_r == `CCAS_PHASE_CYC - 1);

  // ------------------------------------------------------------------------
  // Enable and phase timer
  // ------------------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ring_advance_enable_r <= 1'b0;
      cnt_r                 <= {`CCAS_PHASE_CNT_W{1'b0}};
      o_phase               <= {`CCAS_RING_W{1'b0}};
      o_done                <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !ring_advance_enable_r) begin
        ring_advance_enable_r <= 1'b1;
        cnt_r                 <= {`CCAS_PHASE_CNT_W{1'b0}};
        o_phase               <= `CCAS_RING_FIRST;
      end else if (ring_advance_enable_r) begin
        if (tick) begin
          cnt_r <= {`CCAS_PHASE_CNT_W{1'b0}};
          if (o_phase[`CCAS_RING_W-1]) begin
            o_phase               <= {`CCAS_RING_W{1'b0}};
            ring_advance_enable_r <= 1'b0;
            o_done                <= 1'b1;
          end else begin
            o_phase <= {o_phase[`CCAS_RING_W-2:0], 1'b0};
          end
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule // ccas_ring

// File: ccas_top.v
/*
  Communications chip access sequencer: turns host bit operations on a
  bit-serial I/O bus into chip reset, strobe and timed access cycles.
  Assumes host bus inputs are already on I_MCLK; the bit clock input
  for the chip is generated here from I_MCLK.
*/
// Overview of operation
// - Master reset clears strobe, word select, pointer and write data
// - Hold word select, clear at cycle end
// - Latch chip pointer, preset status at end
// - Ring counter phases are 400 ns wide
// - Ring starts on the strobe pulse, advances only via registered advance enable
// - Supply 32x 9600 bit/s async clock
// - Bit op on reset bit pulses reset
// - Bit op on strobe bit pulses strobe when not busy
`timescale 1ns/1ps
`include "ccas_defs.vh"

module ccas_top (
  // Clock and reset
  input  wire                        I_MCLK,
  input  wire                        I_ARST_N,
  // Host bit-serial bus
  input  wire                        I_BIT_WE,
  input  wire [`CCAS_BIT_ADDR_W-1:0] I_BIT_ADDR,
  input  wire                        I_BIT_DATA,
  input  wire                        I_LOAD,
  input  wire [`CCAS_DATA_W-1:0]     I_LOAD_DATA,
  input  wire                        I_PTR_LOAD,
  input  wire [`CCAS_PTR_W-1:0]      I_PTR_DATA,
  // Chip side
  input  wire [`CCAS_DATA_W-1:0]     I_CHIP_RDATA,
  output reg  [`CCAS_DATA_W-1:0]     O_CHIP_WDATA,
  output reg  [`CCAS_DATA_W-1:0]     O_STORE_DATA,
  output reg  [`CCAS_WSEL_W-1:0]     O_WORD_SEL,
  output reg  [`CCAS_PTR_W-1:0]      O_CHIP_REG_PTR,
  output reg  [`CCAS_RING_W-1:0]     O_RING_PHASE,
  output reg                         O_CHIP_WR,
  output reg                         O_CHIP_RD,
  output reg                         O_BUSY,
  output reg                         O_RESET_PULSE,
  output reg                         O_STROBE_PULSE,
  output reg                         O_BIT_CLK_X32
);

  reg                         strobe_r;
  reg                         strobe_prev_state_r;
  reg                         rd_cycle_r;
  reg [`CCAS_BCLK_CNT_W-1:0]  bclk_cnt_r;
  wire [`CCAS_RING_W-1:0]     ring_phase;
  wire                        ring_done;
  wire                        bit_op;
  wire                        sel_hit;
  wire                        strobe_op;
  wire                        mreset_op;

  assign bit_op    = I_BIT_WE;
  assign sel_hit   = bit_op && (I_BIT_ADDR >= `CCAS_BIT_SEL0)
                            && (I_BIT_ADDR <= `CCAS_BIT_SEL2);
  assign strobe_op = bit_op && (I_BIT_ADDR == `CCAS_BIT_STROBE);
  assign mreset_op = bit_op && (I_BIT_ADDR == `CCAS_BIT_MRESET);

  // ------------------------------------------------------------------------
  // Ring counter
  // ------------------------------------------------------------------------
  ccas_ring u_ring (
    .i_clk    (I_MCLK),
    .i_arst_n (I_ARST_N),
    .i_start  (O_STROBE_PULSE),
    .o_phase  (ring_phase),
    .o_done   (ring_done)
  );

  // ------------------------------------------------------------------------
  // Command decode and pulses
  // ------------------------------------------------------------------------
  always @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      strobe_r            <= 1'b0;
      strobe_prev_state_r <= 1'b0;
      O_RESET_PULSE       <= 1'b0;
      O_STROBE_PULSE      <= 1'b0;
      O_WORD_SEL          <= `CCAS_WSEL_RST;
      O_CHIP_REG_PTR      <= `CCAS_PTR_RST;
      O_CHIP_WDATA        <= `CCAS_DATA_RST;
      O_STORE_DATA        <= `CCAS_DATA_RST;
      O_RING_PHASE        <= {`CCAS_RING_W{1'b0}};
      O_CHIP_WR           <= 1'b0;
      O_CHIP_RD           <= 1'b0;
      O_BUSY              <= 1'b0;
      rd_cycle_r          <= 1'b0;
    end else begin
      strobe_prev_state_r <= strobe_r;
      O_RESET_PULSE       <= mreset_op;
      O_STROBE_PULSE      <= strobe_op && !O_BUSY;
      O_RING_PHASE        <= ring_phase;
      O_CHIP_WR           <= ring_phase[`CCAS_PH_ACCESS] && !rd_cycle_r;
      O_CHIP_RD           <= ring_phase[`CCAS_PH_ACCESS] && rd_cycle_r;
      if (strobe_op) begin
        strobe_r <= I_BIT_DATA;
      end
      if (sel_hit) begin
        O_WORD_SEL[I_BIT_ADDR[1:0]] <= I_BIT_DATA;
      end
      if (I_LOAD) begin
        O_CHIP_WDATA <= I_LOAD_DATA;
      end
      if (I_PTR_LOAD) begin
        O_CHIP_REG_PTR <= I_PTR_DATA;
      end
      if (strobe_op && !O_BUSY) begin
        O_BUSY     <= 1'b1;
        rd_cycle_r <= I_BIT_DATA;
      end
      if (ring_phase[`CCAS_PH_CAPTURE] && rd_cycle_r) begin
        O_STORE_DATA <= I_CHIP_RDATA;
      end
      if (ring_done) begin
        O_BUSY         <= 1'b0;
        O_WORD_SEL     <= `CCAS_WSEL_RST;
        O_CHIP_REG_PTR <= `CCAS_PTR_STATUS;
      end
      if (mreset_op) begin
        strobe_r       <= 1'b0;
        O_WORD_SEL     <= `CCAS_WSEL_RST;
        O_CHIP_REG_PTR <= `CCAS_PTR_RST;
        O_CHIP_WDATA   <= `CCAS_DATA_RST;
      end
    end
  end

  // ------------------------------------------------------------------------
  // 32x async bit clock
  // ------------------------------------------------------------------------
  always @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bclk_cnt_r    <= {`CCAS_BCLK_CNT_W{1'b0}};
      O_BIT_CLK_X32 <= 1'b0;
    end else if (bclk_cnt_r == `CCAS_BCLK_HALF - 1) begin
      bclk_cnt_r    <= {`CCAS_BCLK_CNT_W{1'b0}};
      O_BIT_CLK_X32 <= ~O_BIT_CLK_X32;
    end else begin
      bclk_cnt_r <= bclk_cnt_r + 1'b1;
    end
  end

endmodule // ccas_top

// File: ccas_props.sv
/* Checker on the ports of ccas_top.
   Assumes one clock I_MCLK and async reset I_ARST_N. */
`timescale 1ns/1ps
`include "ccas_defs.vh"
module ccas_props (
  // Clock, reset, host
  input logic                        I_MCLK,
  input logic                        I_ARST_N,
  input logic                        I_BIT_WE,
  input logic [`CCAS_BIT_ADDR_W-1:0] I_BIT_ADDR,
  // Outputs
  input logic [`CCAS_DATA_W-1:0]     O_CHIP_WDATA,
  input logic [`CCAS_WSEL_W-1:0]     O_WORD_SEL,
  input logic [`CCAS_PTR_W-1:0]      O_CHIP_REG_PTR,
  input logic [`CCAS_RING_W-1:0]     O_RING_PHASE,
  input logic                        O_BUSY,
  input logic                        O_RESET_PULSE,
  input logic                        O_STROBE_PULSE,
  input logic                        O_BIT_CLK_X32
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);
  // --------------------------------------------------------------------------
  // Run counters
  // --------------------------------------------------------------------------
  logic [3:0] run_r;
  logic [6:0] bc_r;
  logic       seen_r;
  always @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      run_r <= 4'h0;
      bc_r <= 7'h00;
      seen_r <= 1'b0;
    end else begin
      run_r <= $changed(O_RING_PHASE) ? 4'h0 : run_r + 4'h1;
      bc_r <= $changed(O_BIT_CLK_X32) ? 7'h00 : bc_r + 7'h01;
      seen_r <= seen_r | $changed(O_BIT_CLK_X32);
    end
  end
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  property p_rst; $rose(I_ARST_N) |-> {O_RING_PHASE, O_BUSY, O_WORD_SEL, O_CHIP_REG_PTR,
    O_CHIP_WDATA, O_RESET_PULSE, O_STROBE_PULSE, O_BIT_CLK_X32} == 0; endproperty
  a_rst: assert property (p_rst) else $error("state not cleared");
  property p_mres; I_BIT_WE && I_BIT_ADDR == 4'hc |=> O_RESET_PULSE && O_WORD_SEL == 0; endproperty
  a_mres: assert property (p_mres) else $error("reset pulse missing");
  property p_stb; I_BIT_WE && I_BIT_ADDR == 4'hb && !O_BUSY |=> O_STROBE_PULSE; endproperty
  a_stb: assert property (p_stb) else $error("strobe pulse missing");
  property p_ref; $past(O_BUSY) |-> !O_STROBE_PULSE; endproperty
  a_ref: assert property (p_ref) else $error("strobe while busy");
  property p_ring; O_STROBE_PULSE |-> ##[1:3] O_RING_PHASE == 5'h01; endproperty
  a_ring: assert property (p_ring) else $error("ring not started");
  property p_phase; $changed(O_RING_PHASE) && $past(O_RING_PHASE) != 0 |-> run_r == 4'hf; endproperty
  a_phase: assert property (p_phase) else $error("phase width wrong");
  property p_end; $fell(O_BUSY) |-> O_WORD_SEL == 0 && O_CHIP_REG_PTR == 3'h1; endproperty
  a_end: assert property (p_end) else $error("cycle end state wrong");
  property p_bclk; seen_r && $changed(O_BIT_CLK_X32) |-> bc_r == 7'd64; endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock period wrong");
endmodule // ccas_props
bind ccas_top ccas_props chk_u (.*);

// File: ccas_host.sv
/* Host model issuing bit and multi-bit ops.
   Assumes ops start after reset release. */
`timescale 1ns/1ps
module ccas_host (
  // Clock
  input  logic       clk,
  // Bus
  output logic       we,
  output logic [3:0] addr,
  output logic       dat,
  output logic       ld,
  output logic [7:0] ld_data
);
  initial begin
    {we, addr, dat, ld, ld_data} = 15'h0;
  end
  task bit_op(input logic [3:0] a, input logic v);
    @(posedge clk);
    {we, addr, dat} <= {1'b1, a, v};
    @(posedge clk);
    {we, addr, dat} <= {1'b0, ~a, ~v};
  endtask
  task load(input logic [7:0] d);
    @(posedge clk);
    {ld, ld_data} <= {1'b1, d};
    @(posedge clk);
    {ld, ld_data} <= {1'b0, ~d};
  endtask
endmodule // ccas_host

// File: comm_chip_access_sequencer_bench.sv
/* Bench for ccas_top with host model.
   Assumes 40 MHz clock. */
`timescale 1ns/1ps
module comm_chip_access_sequencer_bench;
  logic clk, rst_n, pl;
  logic [2:0] pd, ws, cp;
  logic [7:0] rd, wd, sd, ldd;
  logic [4:0] ph;
  logic [3:0] ba;
  logic we, bd, ld, busy, rp, sp, cw, cr;
  int fails, check_count, n, wc, rc;
  ccas_top dut_u (.I_MCLK(clk), .I_ARST_N(rst_n), .I_BIT_WE(we), .I_BIT_ADDR(ba),
    .I_BIT_DATA(bd), .I_LOAD(ld), .I_LOAD_DATA(ldd), .I_PTR_LOAD(pl), .I_PTR_DATA(pd),
    .I_CHIP_RDATA(rd), .O_CHIP_WDATA(wd), .O_STORE_DATA(sd), .O_WORD_SEL(ws),
    .O_CHIP_REG_PTR(cp), .O_RING_PHASE(ph), .O_CHIP_WR(cw), .O_CHIP_RD(cr), .O_BUSY(busy),
    .O_RESET_PULSE(rp), .O_STROBE_PULSE(sp), .O_BIT_CLK_X32());
  ccas_host h (.clk(clk), .we(we), .addr(ba), .dat(bd), .ld(ld), .ld_data(ldd));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task idle;
    wc = 0;
    rc = 0;
    for (n = 0; n < 200 && busy !== 1'b0; n++) begin
      @(negedge clk);
      wc += cw;
      rc += cr;
    end
    if (n == 200) begin
      fails++;
      complete_run();
    end
  endtask
  task complete_run;
    $display("fails %0d check_count %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task t_write;
    h.bit_op(4'h8, 1'b1);
    h.bit_op(4'ha, 1'b1);
    h.bit_op(4'h9, 1'b1);
    h.bit_op(4'h9, 1'b0);
    @(negedge clk) chk("word select", 8'h05, ws);
    h.load(8'haa);
    h.bit_op(4'hb, 1'b0);
    @(negedge clk) chk("strobe pulse", 8'h01, sp);
    chk("write data", 8'haa, wd);
    idle();
    chk("write access cycles", 8'h10, wc);
    chk("read access cycles", 8'h00, rc);
    chk("select end", 8'h00, ws);
    chk("pointer end", 8'h01, cp);
  endtask
  task t_read;
    @(posedge clk);
    rd <= 8'h5c;
    pl <= 1'b1;
    pd <= 3'h3;
    @(posedge clk) pl <= 1'b0;
    @(negedge clk) chk("pointer load", 8'h03, cp);
    h.bit_op(4'h8, 1'b1);
    h.bit_op(4'ha, 1'b1);
    h.bit_op(4'hb, 1'b1);
    h.bit_op(4'hb, 1'b1);
    @(negedge clk) chk("refused strobe", 8'h00, sp);
    idle();
    chk("read access cycles", 8'h10, rc);
    chk("write access cycles", 8'h00, wc);
    chk("store data", 8'h5c, sd);
    h.bit_op(4'hb, 1'b0);
    @(negedge clk) idle();
  endtask
  task t_reset;
    h.bit_op(4'hc, 1'b1);
    @(negedge clk) chk("reset pulse", 8'h01, rp);
    h.bit_op(4'hb, 1'b1);
    rst_n <= 1'b0;
    @(negedge clk) chk("busy in reset", 8'h00, busy);
    @(posedge clk) rst_n <= 1'b1;
  endtask
  initial begin
    {rst_n, pl, pd, rd} = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_write();
    t_read();
    repeat (150) @(posedge clk);
    complete_run();
  end
endmodule // comm_chip_access_sequencer_bench
